// file: hdl/phy_regs_pkg.sv
package phy_regs_pkg;

	// ------------------------------------------------------------
	// bus and register geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	// register indices; the byte address is four times the index
	localparam logic [9:0] IDX_RESET_CTRL = 10'h01F;
	localparam logic [9:0] IDX_TEST = 10'h027;
	localparam logic [9:0] IDX_PHASE = 10'h042;
	// field positions
	localparam int RST_FULL_BIT = 15;
	localparam int RST_RESTART_BIT = 14;
	localparam int TEST_MSB_BIT = 5;
	localparam int TEST_FAMILY_BIT = 4;
	localparam int PHASE_EN_BIT = 4;
	// reset values
	localparam logic [5:0] TEST_RST = 6'h00;
	localparam logic [3:0] PHASE_RST = 4'h0;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLOCK_MHZ = 250;
	localparam int RESET_PULSE_NS = 100;
	localparam int RESTART_PULSE_NS = 100;
	localparam int PHASE_STEP_NS = 4;
	localparam int RESET_CYCLES = (RESET_PULSE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int RESTART_CYCLES = (RESTART_PULSE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int STEP_CYCLES = (PHASE_STEP_NS * CLOCK_MHZ + 999) / 1000;
	localparam logic [7:0] RESET_CNT = 8'(RESET_CYCLES - 1);
	localparam logic [7:0] RESTART_CNT = 8'(RESTART_CYCLES - 1);
	localparam logic [3:0] STEP_WAIT = 4'(STEP_CYCLES - 1);
	localparam logic [3:0] PHASE_MAX = 4'hA;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_FULL = 3'h2,
		ST_RESTART = 3'h4
	} ctrl_state_type;

	typedef enum logic [3:0] {
		TP_NLP = 4'h0, TP_PULSE1 = 4'h1, TP_PULSE0 = 4'h2, TP_REP1 = 4'h3,
		TP_REP0 = 4'h4, TP_PREAMBLE = 4'h5, TP_ONE_IDLE = 4'h6, TP_ZERO_IDLE = 4'h7,
		TP_REP1001 = 4'h8, TP_RANDOM = 4'h9, TP_IDLE_00 = 4'hA, TP_IDLE_01 = 4'hB,
		TP_IDLE_11 = 4'hC, TP_RSV_D = 4'hD, TP_RSV_E = 4'hE, TP_RSV_F = 4'hF
	} tp10_pattern_type;

	typedef struct packed {
		logic rst;
		logic test;
		logic phase;
	} reg_hit_type;

	typedef struct packed {
		logic en_10bt;
		tp10_pattern_type pattern;
		logic en_100tx;
		logic [4:0] zeros;
	} test_cfg_type;

	typedef struct packed {
		ctrl_state_type state;
		logic [7:0] cnt;
		logic [5:0] test;
		logic [3:0] phase;
		logic apply;
		logic [DATA_W-1:0] rdata;
		logic ready;
		logic slverr;
		logic phy_reset;
		logic phy_restart;
		test_cfg_type tcfg;
	} regs_state_type;

	typedef struct packed {
		logic busy;
		logic [3:0] target;
		logic [3:0] phase;
		logic [3:0] wait_cnt;
		logic step;
		logic up;
	} stepper_state_type;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic reg_hit_type decode(input logic [ADDR_W-1:0] a);
		reg_hit_type h;
		h.rst = (a == {IDX_RESET_CTRL, 2'b00});
		h.test = (a == {IDX_TEST, 2'b00});
		h.phase = (a == {IDX_PHASE, 2'b00});
		return h;
	endfunction : decode

	// values above the limit fold back by one period
	function automatic logic [3:0] mod10_wrap(input logic [3:0] v);
		return (v > PHASE_MAX) ? 4'(v - PHASE_MAX) : v;
	endfunction : mod10_wrap

	function automatic test_cfg_type test_decode(input logic [5:0] t);
		test_cfg_type c;
		c.en_10bt = t[TEST_FAMILY_BIT] && (t[3:0] <= TP_IDLE_11);
		c.pattern = tp10_pattern_type'(t[3:0]);
		c.en_100tx = !t[TEST_FAMILY_BIT] && ({t[TEST_MSB_BIT], t[3:0]} != 5'h00);
		c.zeros = {t[TEST_MSB_BIT], t[3:0]};
		return c;
	endfunction : test_decode

endpackage : phy_regs_pkg

// file: hdl/tx_phase_stepper.sv
`timescale 1ns/1ns
`default_nettype none

module tx_phase_stepper
	import phy_regs_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// control
	input wire logic clear_i,
	input wire logic apply_i,
	input wire logic [3:0] target_i,
	// clock generator side
	output logic busy_o,
	output logic [3:0] phase_o,
	output logic step_o,
	output logic up_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	stepper_state_type s;
	stepper_state_type next_s;

	// one step of one unit per step period, so the generator only jumps when clear_i sets the phase to zero
	always_comb begin
		next_s = s;
		next_s.step = 1'b0;
		if (s.busy) begin
			if (s.wait_cnt != 4'h0) begin
				next_s.wait_cnt = 4'(s.wait_cnt - 4'h1);
			end else if (s.phase != s.target) begin
				next_s.step = 1'b1;
				next_s.up = (s.target > s.phase);
				next_s.phase = next_s.up ? 4'(s.phase + 4'h1) : 4'(s.phase - 4'h1);
				next_s.wait_cnt = STEP_WAIT;
			end else begin
				next_s.busy = 1'b0;
			end
		end
		// a new request retargets even mid-walk
		if (apply_i) begin
			next_s.target = target_i;
			next_s.busy = 1'b1;
		end
		// full reset puts the clock back to its default phase
		if (clear_i) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state
	assign busy_o = s.busy;
	assign phase_o = s.phase;
	assign step_o = s.step;
	assign up_o = s.up;

endmodule : tx_phase_stepper

`default_nettype wire

// file: hdl/phy_reset_test_clkphase_regs.sv
// Operation
// - writing reset bit 15 resets the whole PHY like the pin, then clears; a write while a restart runs is ignored
// - writing restart bit 14 resets PHY circuitry, keeps registers, then clears
// - reserved bits of the three registers ignore writes and read zero
// - test bit 4 high picks 10Base-T patterns, low picks 100Base-TX
// - in 10Base-T mode bits 3:0 pick one of thirteen patterns
// - 100Base-TX mode sends a one then N zeros, N from 1 to 31
// - bit 5 is the zero count msb, valid only while bit 4 is low
// - selector zero clears the test setup and stops the pattern
// - transmit clock keeps a fixed, adjustable phase to the reference clock
// - phase value counts 4 ns steps, valid range 0 to 10
// - phase values above 10 are stored and applied modulo 10
// - enable bit 4 applies the phase; without it phase stays unchanged
// - bits 3:0 hold phase; change moves clock four ns per unit difference
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module phy_reset_test_clkphase_regs
	import phy_regs_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	// apb slave
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [DATA_W-1:0] PWDATA_I,
	output logic [DATA_W-1:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// phy core reset tree
	output logic PHY_RESET_O,
	output logic PHY_RESTART_O,
	// transmit pattern path
	output test_cfg_type TEST_CFG_O,
	// transmit clock generator
	output logic [3:0] TXCLK_PHASE_O,
	output logic TXCLK_STEP_O,
	output logic TXCLK_STEP_UP_O
);

	// ------------------------------------------------------------
	// state and decode
	// ------------------------------------------------------------
	regs_state_type st;
	regs_state_type next_st;
	reg_hit_type hit;
	logic commit;
	logic wr_rst;
	logic wr_test;
	logic wr_phase;
	logic in_full;
	logic ps_busy;
	logic [REG_W-1:0] rd_word;
	logic [4:0] wsel100;
	logic [3:0] wval;

	// register byte addresses are four times the index:
	// reset control 0x07C, compliance test 0x09C, phase shift 0x108
	// a bad address still gets an answer, with pslverr, so the bus never hangs
	// address compare is shared by read and write paths
	assign hit = decode(PADDR_I);
	// a write lands only at the edge that samples pready high
	assign commit = PSEL_I && PENABLE_I && st.ready && PWRITE_I && !st.slverr;
	assign wr_rst = commit && hit.rst;
	assign wr_test = commit && hit.test;
	assign wr_phase = commit && hit.phase;
	assign in_full = (st.state == ST_FULL);
	assign wsel100 = {PWDATA_I[TEST_MSB_BIT], PWDATA_I[3:0]};
	assign wval = PWDATA_I[3:0];

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	// busy bits read one until the action is over, so software can poll
	always_comb begin
		rd_word = '0;
		if (hit.rst) begin
			rd_word[RST_FULL_BIT] = in_full;
			rd_word[RST_RESTART_BIT] = (st.state == ST_RESTART);
		end else if (hit.test) begin
			rd_word[5:0] = st.test;
		end else if (hit.phase) begin
			rd_word[PHASE_EN_BIT] = st.apply || ps_busy;
			rd_word[3:0] = st.phase;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.apply = 1'b0;
		// one wait state: pready rises in the second access cycle
		next_st.ready = PSEL_I && PENABLE_I && !st.ready;
		next_st.slverr = next_st.ready && (hit == '0);
		if (next_st.ready) begin
			next_st.rdata = {16'h0000, rd_word};
		end
		// a device in full reset takes no register writes
		if (wr_test && !in_full) begin
			// no zeroing enforced
			// software clears first; a direct change simply takes the new value
			next_st.test = PWDATA_I[5:0];
		end
		if (wr_phase && !in_full) begin
			next_st.phase = mod10_wrap(wval);
			next_st.apply = PWDATA_I[PHASE_EN_BIT];
		end
		case (st.state)
			ST_IDLE: begin
				if (wr_rst && PWDATA_I[RST_FULL_BIT]) begin
					next_st.state = ST_FULL;
					next_st.cnt = RESET_CNT;
					next_st.phy_reset = 1'b1;
				end else if (wr_rst && PWDATA_I[RST_RESTART_BIT]) begin
					next_st.state = ST_RESTART;
					next_st.cnt = RESTART_CNT;
					next_st.phy_restart = 1'b1;
				end
			end
			ST_FULL: begin
				if (st.cnt == 8'h00) begin
					next_st.state = ST_IDLE;
					next_st.phy_reset = 1'b0;
					next_st.test = TEST_RST;
					next_st.phase = PHASE_RST;
					next_st.apply = 1'b0;
				end else begin
					next_st.cnt = 8'(st.cnt - 8'h01);
				end
			end
			ST_RESTART: begin
				if (st.cnt == 8'h00) begin
					next_st.state = ST_IDLE;
					next_st.phy_restart = 1'b0;
				end else begin
					next_st.cnt = 8'(st.cnt - 8'h01);
				end
			end
			default: begin
				next_st.state = ST_IDLE;
				next_st.phy_reset = 1'b0;
				next_st.phy_restart = 1'b0;
			end
		endcase
		// the decoded setup is registered with the stored bits, so the
		// pattern path never sees a half-written value
		// family select
		next_st.tcfg = test_decode(next_st.test);
	end

	// the bus handshake survives a soft full reset so the write completes
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			st <= '0;
			st.state <= ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// transmit clock phase stepper
	// ------------------------------------------------------------
	// limitation: a ten-step walk keeps the apply bit busy for about a
	// dozen cycles; software polls rather than waiting a fixed time
	// fixed adjustable phase
	tx_phase_stepper stepper (
		.clock_i(CLOCK_I),
		.nrst_i(NRST_I),
		.clear_i(st.phy_reset),
		.apply_i(st.apply),
		.target_i(st.phase),
		.busy_o(ps_busy),
		.phase_o(TXCLK_PHASE_O),
		.step_o(TXCLK_STEP_O),
		.up_o(TXCLK_STEP_UP_O)
	);

	// outputs straight from the state
	assign PRDATA_O = st.rdata;
	assign PREADY_O = st.ready;
	assign PSLVERR_O = st.slverr;
	assign PHY_RESET_O = st.phy_reset;
	assign PHY_RESTART_O = st.phy_restart;
	assign TEST_CFG_O = st.tcfg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	localparam int RST_LEN = RESET_CYCLES;
	localparam int RSTR_LEN = RESTART_CYCLES;

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!NRST_I);

	AST_FULL_RESET_RUN: assert property (
		(st.state == ST_IDLE) && wr_rst && PWDATA_I[RST_FULL_BIT]
		|=> PHY_RESET_O[*8]
	) else $error("full reset pulse did not start");

	AST_FULL_RESET_LEN: assert property (
		$rose(PHY_RESET_O) |-> ##[RST_LEN:RST_LEN] !PHY_RESET_O
	) else $error("full reset pulse has the wrong length");

	AST_FULL_RESET_CLEAR: assert property (
		$fell(PHY_RESET_O) |-> (st.test == TEST_RST) && (st.phase == PHASE_RST)
			&& !TEST_CFG_O.en_10bt && !TEST_CFG_O.en_100tx
	) else $error("registers not cleared by full reset");

	AST_RESTART_RUN: assert property (
		(st.state == ST_IDLE) && wr_rst && !PWDATA_I[RST_FULL_BIT]
			&& PWDATA_I[RST_RESTART_BIT]
		|=> PHY_RESTART_O[*8] ##[1:RSTR_LEN] (!PHY_RESTART_O && st.state == ST_IDLE)
	) else $error("restart pulse wrong or not self clearing");

	AST_RESTART_KEEP: assert property (
		PHY_RESTART_O && !wr_test && !wr_phase |=> $stable(st.test) && $stable(st.phase)
	) else $error("restart disturbed register contents");

	AST_RESERVED_ZERO: assert property (
		PREADY_O |-> (PRDATA_O[31:16] == 16'h0000)
			&& (!hit.rst || PRDATA_O[13:0] == 14'h0000)
			&& (!hit.test || PRDATA_O[15:6] == 10'h000)
			&& (!hit.phase || PRDATA_O[15:5] == 11'h000)
	) else $error("reserved bits read nonzero");

	AST_FAMILY_EXCL: assert property (
		(TEST_CFG_O.en_10bt |-> st.test[TEST_FAMILY_BIT])
			&& !(TEST_CFG_O.en_10bt && TEST_CFG_O.en_100tx)
	) else $error("test family select broken");

	AST_100TX_SEL: assert property (
		wr_test && !in_full && !PWDATA_I[TEST_FAMILY_BIT]
		|=> (TEST_CFG_O.en_100tx == ($past(wsel100) != 5'h00))
			&& (TEST_CFG_O.zeros == $past(wsel100))
	) else $error("100Base-TX selector not applied");

	AST_PHASE_WRAP: assert property (
		wr_phase && !in_full |=> st.phase == mod10_wrap($past(wval))
	) else $error("phase value not folded");

	AST_PHASE_RANGE: assert property (
		(st.phase <= PHASE_MAX) && (TXCLK_PHASE_O <= PHASE_MAX)
	) else $error("phase value out of range");

	AST_PHASE_HOLD: assert property (
		$changed(TXCLK_PHASE_O) |-> (TXCLK_STEP_O && $past(ps_busy)) || $past(PHY_RESET_O)
	) else $error("transmit clock phase moved without enable");

	AST_PHASE_REACH: assert property (
		st.apply && !PHY_RESET_O |-> ##[1:24] (!ps_busy && TXCLK_PHASE_O == st.phase)
	) else $error("transmit clock phase did not settle");

	AST_FULL_WINS: assert property (
		(st.state == ST_IDLE) && wr_rst && PWDATA_I[RST_FULL_BIT] |=> !PHY_RESTART_O
	) else $error("restart started alongside a full reset");

	AST_FULL_SELF_CLEAR: assert property (
		$fell(PHY_RESET_O) |-> (st.state == ST_IDLE)
	) else $error("full reset state did not return to idle");

	AST_FULL_NO_STEP: assert property (
		PHY_RESET_O && $past(PHY_RESET_O) |-> !TXCLK_STEP_O && (TXCLK_PHASE_O == 4'h0)
	) else $error("transmit clock stepped during full reset");

	AST_FULL_BLOCKS_WRITE: assert property (
		in_full && (wr_test || wr_phase) && (st.cnt != 8'h00)
		|=> $stable(st.test) && $stable(st.phase)
	) else $error("register write landed during full reset");

	AST_RESTART_SELF_CLEAR: assert property (
		$fell(PHY_RESTART_O) |-> (st.state == ST_IDLE) && !PHY_RESET_O
	) else $error("restart state did not return to idle");

	AST_RESTART_EXCL: assert property (
		PHY_RESTART_O |-> !PHY_RESET_O
	) else $error("restart and full reset both active");

	AST_10BT_PATTERN: assert property (
		((st.test[TEST_FAMILY_BIT] && (st.test[3:0] <= TP_IDLE_11))
			== TEST_CFG_O.en_10bt)
			&& (TEST_CFG_O.pattern == st.test[3:0])
	) else $error("10Base-T pattern select broken");

	AST_100TX_COUNT: assert property (
		((!st.test[TEST_FAMILY_BIT] && ({st.test[TEST_MSB_BIT], st.test[3:0]} != 5'h00))
			== TEST_CFG_O.en_100tx)
			&& (TEST_CFG_O.zeros == {st.test[TEST_MSB_BIT], st.test[3:0]})
	) else $error("100Base-TX zero count broken");

	AST_100TX_MSB: assert property (
		TEST_CFG_O.en_100tx |-> !st.test[TEST_FAMILY_BIT]
			&& (TEST_CFG_O.zeros[4] == st.test[TEST_MSB_BIT])
	) else $error("100Base-TX count msb broken");

	AST_PHASE_STILL: assert property (
		!st.apply && !ps_busy && !PHY_RESET_O |=> $stable(TXCLK_PHASE_O)
	) else $error("transmit clock phase moved while idle");

	AST_STEP_SIZE: assert property (
		TXCLK_STEP_O |-> TXCLK_PHASE_O == (TXCLK_STEP_UP_O
			? 4'($past(TXCLK_PHASE_O) + 4'h1) : 4'($past(TXCLK_PHASE_O) - 4'h1))
	) else $error("transmit clock step was not one unit");

	AST_PHASE_READ: assert property (
		PREADY_O && hit.phase |-> (PRDATA_O[3:0] == $past(st.phase))
			&& (PRDATA_O[PHASE_EN_BIT] == ($past(st.apply) || $past(ps_busy)))
	) else $error("phase register read back wrong");

	AST_RESET_READ: assert property (
		PREADY_O && hit.rst |-> (PRDATA_O[RST_FULL_BIT] == $past(PHY_RESET_O))
			&& (PRDATA_O[RST_RESTART_BIT] == $past(PHY_RESTART_O))
	) else $error("reset control busy bits read back wrong");

	COV_FULL_RESET: cover property ($fell(PHY_RESET_O));
	COV_RESTART: cover property ($fell(PHY_RESTART_O));
	COV_10BT: cover property (TEST_CFG_O.en_10bt && TEST_CFG_O.pattern == TP_RANDOM);
	COV_PHASE_DOWN: cover property (TXCLK_STEP_O && !TXCLK_STEP_UP_O);
	COV_100TX: cover property (TEST_CFG_O.en_100tx && TEST_CFG_O.zeros == 5'h1F);

endmodule : phy_reset_test_clkphase_regs

`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import phy_regs_pkg::*;

	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic phy_reset;
	logic phy_restart;
	test_cfg_type tcfg;
	logic [3:0] phase;
	logic step;
	logic step_up;
	int fails = 0;
	int n_checks = 0;
	int n_step = 0;
	int n_rst = 0;
	int n_rs = 0;
	logic [DATA_W-1:0] rd;
	logic err;
	localparam logic [ADDR_W-1:0] A_RST = {IDX_RESET_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] A_TEST = {IDX_TEST, 2'b00};
	localparam logic [ADDR_W-1:0] A_PH = {IDX_PHASE, 2'b00};

	// 4 ns period
	always #2 clock_i = ~clock_i;

	phy_reset_test_clkphase_regs uut (
		.CLOCK_I(clock_i), .NRST_I(nrst_i), .PADDR_I(paddr), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .PHY_RESET_O(phy_reset),
		.PHY_RESTART_O(phy_restart), .TEST_CFG_O(tcfg), .TXCLK_PHASE_O(phase),
		.TXCLK_STEP_O(step), .TXCLK_STEP_UP_O(step_up)
	);

	// pulse counters sampled mid-cycle, away from the launching edge
	always @(negedge clock_i) begin
		if (step === 1'b1) n_step++;
		if (phy_reset === 1'b1) n_rst++;
		if (phy_restart === 1'b1) n_rs++;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one apb transfer; pready and the answer are taken at the rising edge
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do begin
			@(posedge clock_i);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) chk("pready", 32'(pready), 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, rd, exp);
		chk("slverr", 32'(err), 32'h0);
	endtask : rdc

	// poll until the apply bit has cleared itself
	task automatic wait_ph;
		int k;
		for (k = 0; k < 40; k++) begin
			apb(1'b0, A_PH, 32'h0);
			if (rd[PHASE_EN_BIT] === 1'b0) break;
		end
		chk("phase apply done", 32'(rd[PHASE_EN_BIT]), 32'h0);
	endtask : wait_ph

	task automatic wait_pulse;
		int k;
		repeat (2) @(negedge clock_i);
		for (k = 0; k < 100 && (phy_reset === 1'b1 || phy_restart === 1'b1); k++)
			@(negedge clock_i);
	endtask : wait_pulse

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	initial begin
		#100000;
		fails++;
		results();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int c;
		logic [4:0] n;
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
		// reset values and an unmapped place
		rdc("reset ctrl", A_RST, 32'h0);
		rdc("test reg", A_TEST, 32'h0);
		rdc("phase reg", A_PH, 32'h0);
		apb(1'b0, 12'h080, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		chk("unmapped data", rd, 32'h0);
		// reserved test bits vanish
		wr(A_TEST, 32'hFFFF_FFFF);
		rdc("test reserved", A_TEST, 32'h3F);
		// speed taken as forced
		// every 10Base-T code; codes above 0xC stay silent
		for (c = 0; c < 16; c++) begin
			wr(A_TEST, 32'h10 | c);
			repeat (2) @(negedge clock_i);
			chk("cfg 10bt", 32'(tcfg), {21'h0, c <= 12, 4'(c), 2'b00, 4'(c)});
		end
		// 100Base-TX counts, cleared before each new one
		for (c = 0; c < 3; c++) begin
			n = (c == 0) ? 5'd1 : ((c == 1) ? 5'd16 : 5'd31);
			wr(A_TEST, 32'h0);
			wr(A_TEST, {26'h0, n[4], 1'b0, n[3:0]});
			repeat (2) @(negedge clock_i);
			chk("cfg 100tx", 32'(tcfg), {21'h0, 1'b0, n[3:0], 1'b1, n});
		end
		wr(A_TEST, 32'h0);
		repeat (2) @(negedge clock_i);
		chk("cfg cleared", 32'(tcfg), 32'h0);
		// phase walk up, store without apply, walk down, wrap
		n_step = 0;
		wr(A_PH, 32'h12);
		wait_ph();
		wr(A_PH, 32'h19);
		wait_ph();
		chk("steps 0 to 9", 32'(n_step), 32'd9);
		chk("phase 9", 32'(phase), 32'h9);
		chk("dir up", 32'(step_up), 32'h1);
		rdc("phase read 9", A_PH, 32'h9);
		wr(A_PH, 32'h0F);
		rdc("phase wrap 15", A_PH, 32'h5);
		chk("phase held", 32'(phase), 32'h9);
		n_step = 0;
		wr(A_PH, 32'h13);
		wait_ph();
		chk("steps 9 to 3", 32'(n_step), 32'd6);
		chk("phase 3", 32'(phase), 32'h3);
		chk("dir down", 32'(step_up), 32'h0);
		wr(A_PH, 32'hFFFF_FFEC);
		rdc("phase reserved", A_PH, 32'h2);
		wr(A_PH, 32'h1A);
		wait_ph();
		chk("phase 10", 32'(phase), 32'hA);
		// restart keeps registers
		wr(A_TEST, 32'h25);
		n_rs = 0;
		wr(A_RST, 32'h4000);
		rdc("restart running", A_RST, 32'h4000);
		wait_pulse();
		chk("restart length", 32'(n_rs), 32'd25);
		rdc("restart cleared", A_RST, 32'h0);
		rdc("test kept", A_TEST, 32'h25);
		rdc("phase kept", A_PH, 32'hA);
		chk("phase out kept", 32'(phase), 32'hA);
		// full reset wins over restart and clears everything
		n_rst = 0;
		n_rs = 0;
		n_step = 0;
		wr(A_RST, 32'hC000);
		// writes while the reset runs are refused
		wr(A_TEST, 32'h25);
		wr(A_RST, 32'h4000);
		wait_pulse();
		chk("reset length", 32'(n_rst), 32'd25);
		chk("no restart", 32'(n_rs), 32'd0);
		chk("no steps", 32'(n_step), 32'd0);
		chk("phase out 0", 32'(phase), 32'h0);
		chk("cfg reset", 32'(tcfg), 32'h0);
		rdc("reset cleared", A_RST, 32'h0);
		rdc("test reset", A_TEST, 32'h0);
		rdc("phase reset", A_PH, 32'h0);
		// reserved control bits start nothing
		wr(A_RST, 32'h3FFF);
		repeat (4) @(negedge clock_i);
		chk("reserved ctrl", 32'(n_rst + n_rs), 32'd25);
		rdc("reserved ctrl read", A_RST, 32'h0);
		results();
	end

endmodule : tb_top

`default_nettype wire
